// ===== src/serial_port_map.vh
// register map, field positions and timing constants for the serial port
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH
`define SFR_BASE            8'h80
`define ADDR_SERIAL_CONTROL 8'h98
`define ADDR_SERIAL_DATA    8'h99
`define ADDR_IRQ_ENABLE     8'ha8
`define ADDR_SLAVE_ADDRESS  8'ha9
`define ADDR_SLAVE_MASK     8'hb9
`define SC_MODE_HI          7
`define SC_MODE_LO          6
`define SC_MULTIPROC        5
`define SC_RX_ENABLE        4
`define SC_TX_NINTH         3
`define SC_RX_NINTH         2
`define SC_TX_DONE          1
`define SC_RX_DONE          0
`define IE_GLOBAL           7
`define IE_SERIAL           4
`define RESET_SERIAL_CONTROL 8'h00
`define RESET_IRQ_ENABLE    8'h00
`define RESET_SLAVE_ADDRESS 8'h00
`define RESET_SLAVE_MASK    8'h00
`define SYNC_DIV_FAST       8'd4
`define SYNC_DIV_SLOW       8'd12
`define FIXED_DIV_MODE2     8'd32
`define FIXED_DIV_MODE2_X2  8'd64
`endif

// ===== src/serial_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module serial_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    rd_ptr;
    reg [AW-1:0]    wr_ptr;
    reg [AW:0]      count;
    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;
    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    always @(posedge clk) begin
        if (!rst_n) begin
            rd_ptr <= {AW{1'b0}};
            wr_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule // serial_fifo
`default_nettype wire

// ===== src/serial_baud_gen.v
// bit-rate tick generator: divides clk by a runtime ratio
`timescale 1ns/1ps
`default_nettype none
module serial_baud_gen #(
    parameter DW = 16
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          run,
    input  wire [DW-1:0] divide,
    output reg           tick
);
    reg [DW-1:0] count;
    always @(posedge clk) begin
        if (!rst_n || !run) begin
            count <= {DW{1'b0}};
            tick  <= 1'b0;
        end else if (count >= divide - 1'b1) begin
            count <= {DW{1'b0}};
            tick  <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule // serial_baud_gen
`default_nettype wire

// ===== src/serial_port_sfr_control.v
// serial port register block with transmitter, receiver and address match
//
// Function
// - registers only at 80-ffh, direct address
// - bit writes where address ends 0/8
// - mode bits pick frame length, rate
// - fast setting makes mode 0 clk/4
// - receive only while receive enable set
// - modes 2/3 send software ninth bit
// - ninth bit or stop bit into rx field
// - tx flag at bit 8 / stop start
// - data read is rx, write is tx
// - mask zero bits are don't care
// - ie bit 4 enables serial interrupt
// - ie bit 7 gates all interrupts
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.vh"
module serial_port_sfr_control #(
    parameter [15:0] VAR_DIVIDE = 16'd108,
    parameter        FIFO_DEPTH = 4
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [7:0] sfr_addr,
    input  wire       sfr_direct,
    input  wire       sfr_wr,
    input  wire       sfr_rd,
    input  wire       sfr_bit_wr,
    input  wire [2:0] sfr_bit_sel,
    input  wire       sfr_bit_val,
    input  wire [7:0] sfr_wdata,
    output reg  [7:0] sfr_rdata,
    output wire       sfr_hit,
    input  wire       sync_fast,
    input  wire       double_rate,
    input  wire       rxd_in,
    output reg        txd_out,
    output reg        sync_clk_out,
    output wire       tx_fifo_ready,
    output reg        serial_irq
);
    reg [7:0] serial_control_reg;
    reg [7:0] rx_buffer;
    reg [7:0] interrupt_enable_reg;
    reg [7:0] slave_address_reg;
    reg [7:0] slave_address_mask_reg;

    wire frame_mode_sel_hi    = serial_control_reg[`SC_MODE_HI];
    wire frame_mode_sel_lo    = serial_control_reg[`SC_MODE_LO];
    wire multiproc_enable_bit = serial_control_reg[`SC_MULTIPROC];
    wire rx_enable            = serial_control_reg[`SC_RX_ENABLE];
    wire tx_ninth_bit         = serial_control_reg[`SC_TX_NINTH];
    wire rx_ninth_bit         = serial_control_reg[`SC_RX_NINTH];
    wire tx_done_flag         = serial_control_reg[`SC_TX_DONE];
    wire rx_done_flag         = serial_control_reg[`SC_RX_DONE];
    wire global_irq_gate      = interrupt_enable_reg[`IE_GLOBAL];
    wire serial_irq_enable    = interrupt_enable_reg[`IE_SERIAL];
    wire [1:0] mode = {frame_mode_sel_hi, frame_mode_sel_lo};

    function in_sfr;
        input [7:0] a;
        input       direct;
        begin
            in_sfr = direct && (a >= `SFR_BASE);
        end
    endfunction
    // bit addressable ends in 0 or 8
    function bit_addressable;
        input [7:0] a;
        begin
            bit_addressable = (a[2:0] == 3'h0);
        end
    endfunction
    function [7:0] set_bit;
        input [7:0] v;
        input [2:0] sel;
        input       b;
        reg   [7:0] m;
        begin
            m = 8'h01 << sel;
            set_bit = b ? (v | m) : (v & ~m);
        end
    endfunction

    wire acc       = in_sfr(sfr_addr, sfr_direct);
    wire bit_ok    = sfr_bit_wr && acc && bit_addressable(sfr_addr);
    wire byte_wr   = sfr_wr && acc;
    wire hit_ctrl  = sfr_addr == `ADDR_SERIAL_CONTROL;
    wire hit_data  = sfr_addr == `ADDR_SERIAL_DATA;
    wire hit_ie    = sfr_addr == `ADDR_IRQ_ENABLE;
    wire hit_sa    = sfr_addr == `ADDR_SLAVE_ADDRESS;
    wire hit_mask  = sfr_addr == `ADDR_SLAVE_MASK;
    assign sfr_hit = acc && (hit_ctrl || hit_data || hit_ie || hit_sa || hit_mask);

    wire [7:0] fifo_out;
    wire       fifo_valid;
    reg        fifo_take;
    serial_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(2)) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (sfr_wdata),
        .in_valid  (byte_wr && hit_data),
        .in_ready  (tx_fifo_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (fifo_take)
    );

    reg [15:0] divide;
    always @* begin
        case (mode)
            2'b00:   divide = sync_fast ? {8'h00, `SYNC_DIV_FAST} : {8'h00, `SYNC_DIV_SLOW};
            2'b10:   divide = double_rate ? {8'h00, `FIXED_DIV_MODE2} :
                                            {8'h00, `FIXED_DIV_MODE2_X2};
            default: divide = VAR_DIVIDE;
        endcase
    end
    wire frame_bits_11 = frame_mode_sel_hi;
    wire tx_tick;
    reg  tx_busy;
    serial_baud_gen #(.DW(16)) u_baud (
        .clk    (clk),
        .rst_n  (rst_n),
        .run    (1'b1),
        .divide (divide),
        .tick   (tx_tick)
    );

    // transmitter
    reg [10:0] tx_shift;
    reg [3:0]  tx_cnt;
    reg        tx_done_set;
    always @(posedge clk) begin
        if (!rst_n) begin
            tx_busy      <= 1'b0;
            tx_shift     <= 11'h7ff;
            tx_cnt       <= 4'h0;
            txd_out      <= 1'b1;
            sync_clk_out <= 1'b1;
            tx_done_set  <= 1'b0;
            fifo_take    <= 1'b0;
        end else begin
            tx_done_set <= 1'b0;
            fifo_take   <= 1'b0;
            if (!tx_busy) begin
                if (fifo_valid && !fifo_take) begin
                    tx_busy  <= 1'b1;
                    fifo_take <= 1'b1;
                    tx_cnt   <= 4'h0;
                    tx_shift <= (mode == 2'b00) ? {3'h7, fifo_out} :
                                frame_bits_11 ? {1'b1, tx_ninth_bit, fifo_out, 1'b0} :
                                                {2'h3, fifo_out, 1'b0};
                end
            end else if (tx_tick) begin
                txd_out  <= tx_shift[0];
                tx_shift <= {1'b1, tx_shift[10:1]};
                tx_cnt   <= tx_cnt + 4'h1;
                sync_clk_out <= (mode == 2'b00) ? 1'b0 : 1'b1;
                // end of 8th bit in mode 0, stop start otherwise
                if ((mode == 2'b00 && tx_cnt == 4'd8) ||
                    (mode != 2'b00 && tx_cnt == (frame_bits_11 ? 4'd10 : 4'd9))) begin
                    tx_done_set <= 1'b1;
                    tx_busy     <= 1'b0;
                    sync_clk_out <= 1'b1;
                end
            end else begin
                sync_clk_out <= 1'b1;
            end
        end
    end

    // receive pin synchroniser, three stages
    reg [2:0] rx_sync;
    reg       rx_level;
    always @(posedge clk) begin
        if (!rst_n) begin
            rx_sync  <= 3'h7;
            rx_level <= 1'b1;
        end else begin
            rx_sync <= {rx_sync[1:0], rxd_in};
            if (rx_sync[2] == rx_sync[1]) begin
                rx_level <= rx_sync[1];
            end
        end
    end

    // receiver, asynchronous modes, mid-bit sampling
    reg [15:0] rx_div;
    reg [3:0]  rx_cnt;
    reg [9:0]  rx_shift;
    reg        rx_busy;
    reg        rx_done_set;
    reg [7:0]  rx_byte;
    reg        rx_ninth_val;
    wire [3:0] rx_last = frame_bits_11 ? 4'd10 : 4'd9;
    wire addr_match = ((rx_shift[8:1] ^ slave_address_reg) & slave_address_mask_reg) == 8'h00;
    always @(posedge clk) begin
        if (!rst_n) begin
            rx_busy     <= 1'b0;
            rx_div      <= 16'h0000;
            rx_cnt      <= 4'h0;
            rx_shift    <= 10'h000;
            rx_done_set <= 1'b0;
            rx_byte     <= 8'h00;
            rx_ninth_val <= 1'b0;
        end else begin
            rx_done_set <= 1'b0;
            if (!rx_enable || mode == 2'b00) begin
                rx_busy <= 1'b0;
            end else if (!rx_busy) begin
                if (!rx_level) begin
                    rx_busy <= 1'b1;
                    rx_div  <= {1'b0, divide[15:1]};
                    rx_cnt  <= 4'h0;
                end
            end else if (rx_div != 16'h0000) begin
                rx_div <= rx_div - 16'h0001;
            end else begin
                rx_div   <= divide - 16'h0001;
                rx_shift <= {rx_level, rx_shift[9:1]};
                rx_cnt   <= rx_cnt + 4'h1;
                if (rx_cnt == 4'h0 && rx_level) begin
                    rx_busy <= 1'b0;
                end else if (rx_cnt == rx_last) begin
                    rx_busy <= 1'b0;
                    if (!multiproc_enable_bit ||
                        (frame_bits_11 ? (rx_shift[9] && addr_match) : rx_level)) begin
                        rx_done_set  <= 1'b1;
                        rx_byte      <= frame_bits_11 ? rx_shift[8:1] : rx_shift[9:2];
                        rx_ninth_val <= frame_bits_11 ? rx_shift[9] : rx_level;
                    end
                end
            end
        end
    end

    // register writes; hardware set wins over software clear
    reg [7:0] next_ctrl;
    always @* begin
        next_ctrl = serial_control_reg;
        if (byte_wr && hit_ctrl) begin
            next_ctrl = sfr_wdata;
        end else if (bit_ok && hit_ctrl) begin
            next_ctrl = set_bit(serial_control_reg, sfr_bit_sel, sfr_bit_val);
        end
        if (tx_done_set) begin
            next_ctrl[`SC_TX_DONE] = 1'b1;
        end
        if (rx_done_set) begin
            next_ctrl[`SC_RX_DONE] = 1'b1;
            if (mode != 2'b00) begin
                next_ctrl[`SC_RX_NINTH] = rx_ninth_val;
            end
        end
    end
    always @(posedge clk) begin
        if (!rst_n) begin
            serial_control_reg     <= `RESET_SERIAL_CONTROL;
            interrupt_enable_reg   <= `RESET_IRQ_ENABLE;
            slave_address_reg      <= `RESET_SLAVE_ADDRESS;
            slave_address_mask_reg <= `RESET_SLAVE_MASK;
            rx_buffer              <= 8'h00;
            serial_irq             <= 1'b0;
        end else begin
            serial_control_reg <= next_ctrl;
            if (rx_done_set) begin
                rx_buffer <= rx_byte;
            end
            if (byte_wr && hit_ie) begin
                interrupt_enable_reg <= sfr_wdata;
            end else if (bit_ok && hit_ie) begin
                interrupt_enable_reg <= set_bit(interrupt_enable_reg, sfr_bit_sel, sfr_bit_val);
            end
            if (byte_wr && hit_sa) begin
                slave_address_reg <= sfr_wdata;
            end
            if (byte_wr && hit_mask) begin
                slave_address_mask_reg <= sfr_wdata;
            end
            serial_irq <= global_irq_gate && serial_irq_enable &&
                          (tx_done_flag || rx_done_flag);
        end
    end

    always @* begin
        sfr_rdata = 8'h00;
        if (sfr_rd && acc) begin
            if (hit_ctrl) begin
                sfr_rdata = serial_control_reg;
            end else if (hit_data) begin
                sfr_rdata = rx_buffer;
            end else if (hit_ie) begin
                sfr_rdata = interrupt_enable_reg;
            end else if (hit_sa) begin
                sfr_rdata = slave_address_reg;
            end else if (hit_mask) begin
                sfr_rdata = slave_address_mask_reg;
            end
        end
    end
    wire unused_ninth = rx_ninth_bit;
endmodule // serial_port_sfr_control
`default_nettype wire

// ===== sim/serial_port_monitor.sv
// assertion checker for the serial port register block
`timescale 1ns/1ps
`default_nettype none
module serial_port_monitor (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_direct,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic       sfr_bit_wr,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic       sfr_bit_val,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       sfr_hit,
    input wire logic       txd_out,
    input wire logic       sync_clk_out,
    input wire logic       serial_irq
);
    logic [7:0] ie_sh;
    logic [7:0] sa_sh;
    logic [7:0] sm_sh;
    logic [1:0] mode_sh;
    wire        wok = sfr_direct && sfr_wr;
    wire        bok = sfr_direct && sfr_bit_wr;
    wire        sel = sfr_rd && sfr_direct;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ie_sh <= 8'h00;
            sa_sh <= 8'h00;
            sm_sh <= 8'h00;
            mode_sh <= 2'h0;
        end else begin
            if (wok && sfr_addr == 8'ha8) ie_sh <= sfr_wdata;
            if (wok && sfr_addr == 8'ha9) sa_sh <= sfr_wdata;
            if (wok && sfr_addr == 8'hb9) sm_sh <= sfr_wdata;
            if (wok && sfr_addr == 8'h98) mode_sh <= sfr_wdata[7:6];
            if (bok && sfr_addr == 8'ha8) ie_sh[sfr_bit_sel] <= sfr_bit_val;
            if (bok && sfr_addr == 8'h98 && sfr_bit_sel[2:1] == 2'h3)
                mode_sh[sfr_bit_sel[0]] <= sfr_bit_val;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_low_pulse;
        !sync_clk_out ##1 sync_clk_out;
    endsequence
    chk_hit_decode: assert property (sfr_hit == (sfr_direct && (sfr_addr == 8'h98 ||
        sfr_addr == 8'h99 || sfr_addr == 8'ha8 || sfr_addr == 8'ha9 || sfr_addr == 8'hb9)))
        else $error("hit flag wrong");
    chk_rdata_idle: assert property (!sfr_rd |-> sfr_rdata == 8'h00)
        else $error("read data not zero");
    chk_read_unmapped: assert property (sfr_rd && !sfr_hit |-> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_read_shadow: assert property (sel && sfr_addr[7:4] != 4'h9 |->
        sfr_rdata == (sfr_addr == 8'ha8 ? ie_sh : sfr_addr == 8'ha9 ? sa_sh :
        sfr_addr == 8'hb9 ? sm_sh : 8'h00)) else $error("register read wrong");
    chk_irq_gate: assert property (serial_irq |-> $past(ie_sh[7] && ie_sh[4]))
        else $error("irq while disabled");
    chk_tx_reset: assert property ($rose(rst_n) |-> txd_out && sync_clk_out && !serial_irq)
        else $error("outputs not idle");
    chk_sync_mode0: assert property (!sync_clk_out |-> mode_sh == 2'h0)
        else $error("shift clock outside mode 0");
    chk_sync_pulse: assert property ($fell(sync_clk_out) |-> s_low_pulse)
        else $error("shift clock low too long");
endmodule // serial_port_monitor
bind serial_port_sfr_control serial_port_monitor mon_u (.clk(clk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_direct(sfr_direct), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .txd_out(txd_out),
    .sync_clk_out(sync_clk_out), .serial_irq(serial_irq));
`default_nettype wire

// ===== sim/serial_line_partner.sv
// far-end serial sender: drives frames onto the receive line
`timescale 1ns/1ps
`default_nettype none
module serial_line_partner #(
    parameter int BIT_CYC = 16
) (
    input wire logic clk,
    output var logic line
);
    initial line = 1'b1;
    task automatic send(input logic [7:0] d, input logic nine, input logic b9);
        @(negedge clk);
        line = 1'b0;
        repeat (BIT_CYC) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            line = d[i];
            repeat (BIT_CYC) @(negedge clk);
        end
        // optional ninth bit for the 11-bit frames
        if (nine) begin
            line = b9;
            repeat (BIT_CYC) @(negedge clk);
        end
        // idle high between frames
        line = 1'b1;
        repeat (BIT_CYC * 3) @(negedge clk);
    endtask
endmodule // serial_line_partner
`default_nettype wire

// ===== sim/serial_port_sfr_control_tb_top.sv
// testbench for the serial port register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
    $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module serial_port_sfr_control_tb_top;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic       sfr_direct = 1'b1;
    logic       sfr_wr = 1'b0;
    logic       sfr_rd = 1'b0;
    logic       sfr_bit_wr = 1'b0;
    logic [2:0] sfr_bit_sel = 3'h0;
    logic       sfr_bit_val = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic       sync_fast = 1'b0;
    logic       double_rate = 1'b1;
    wire  [7:0] sfr_rdata;
    wire        sfr_hit, rxd_in, txd_out, sync_clk_out, tx_fifo_ready, serial_irq;
    int         err_total = 0;
    int         total_checks = 0;
    logic [7:0] q;
    always #2.5 clk = ~clk;
    serial_port_sfr_control #(.VAR_DIVIDE(16'd16), .FIFO_DEPTH(4)) dut_u (.clk(clk),
        .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_direct(sfr_direct), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
        .sfr_bit_val(sfr_bit_val), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .sync_fast(sync_fast), .double_rate(double_rate),
        .rxd_in(rxd_in), .txd_out(txd_out), .sync_clk_out(sync_clk_out),
        .tx_fifo_ready(tx_fifo_ready), .serial_irq(serial_irq));
    serial_line_partner #(.BIT_CYC(16)) partner_u (.clk(clk), .line(rxd_in));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic bwr(input logic [7:0] a, input logic [2:0] s, input logic v);
        sfr_addr = a;
        sfr_bit_sel = s;
        sfr_bit_val = v;
        sfr_bit_wr = 1'b1;
        @(negedge clk);
        sfr_bit_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_addr = a;
        sfr_rd = 1'b1;
        #1 d = sfr_rdata;
        @(negedge clk);
        sfr_rd = 1'b0;
        @(negedge clk);
    endtask
    task automatic get_frame(input int nb, output logic [10:0] b, output int w);
        int k;
        w = 0;
        k = 0;
        b = 11'h000;
        while (txd_out !== 1'b0 && k < 5000) begin @(negedge clk); k++; end
        while (txd_out === 1'b0 && w < 500) begin @(negedge clk); w++; end
        repeat (w / 2) @(negedge clk);
        for (int i = 0; i < nb; i++) begin b[i] = txd_out; repeat (w) @(negedge clk); end
    endtask
    task automatic t_regs;
        rd(8'h98, q); `CHK(q, 8'h00)
        rd(8'ha8, q); `CHK(q, 8'h00)
        rd(8'h80, q); `CHK(q, 8'h00)
        sfr_direct = 1'b0;
        wr(8'ha9, 8'h33);
        sfr_direct = 1'b1;
        rd(8'ha9, q); `CHK(q, 8'h00)
        // slave address and mask set by software
        wr(8'ha9, 8'h5a);
        wr(8'hb9, 8'hf3);
        rd(8'ha9, q); `CHK(q, 8'h5a)
        rd(8'hb9, q); `CHK(q, 8'hf3)
        bwr(8'ha9, 3'h0, 1'b1);
        rd(8'ha9, q); `CHK(q, 8'h5a)
        bwr(8'ha8, 3'h4, 1'b1);
        bwr(8'ha8, 3'h7, 1'b1);
        rd(8'ha8, q); `CHK(q, 8'h90)
        $display("test regs done");
    endtask
    task automatic t_tx(input logic [7:0] c, input logic [7:0] d, input int nb,
                        input logic [10:0] e);
        logic [10:0] b;
        int          w;
        wr(8'h98, c);
        wr(8'h99, d);
        get_frame(nb, b, w);
        `CHK(b, e)
        if (c[7:6] == 2'b10) `CHK(w, double_rate ? 32 : 64)
        rd(8'h98, q); `CHK(q[1], 1'b1)
        `CHK(serial_irq, 1'b1)
        bwr(8'ha8, 3'h7, 1'b0);
        `CHK(serial_irq, 1'b0)
        bwr(8'ha8, 3'h7, 1'b1);
        `CHK(serial_irq, 1'b1)
        bwr(8'h98, 3'h1, 1'b0);
        `CHK(serial_irq, 1'b0)
        $display("test tx done");
    endtask
    task automatic t_sync(input logic f, input int sp);
        int k;
        int n;
        sync_fast = f;
        wr(8'h98, 8'h00);
        wr(8'h99, 8'h5a);
        k = 0;
        n = 0;
        while (sync_clk_out !== 1'b0 && k < 200) begin @(negedge clk); k++; end
        for (k = 0; k < 300; k++) begin
            if (sync_clk_out === 1'b0) n++;
            if (k == 1) `CHK(sync_clk_out, 1'b1)
            @(negedge clk);
            if (n == 1 && sync_clk_out === 1'b0) `CHK(k + 1, sp)
        end
        `CHK(n, 8)
        rd(8'h98, q); `CHK(q[1], 1'b1)
        bwr(8'h98, 3'h1, 1'b0);
        $display("test sync done");
    endtask
    task automatic t_rx;
        wr(8'h98, 8'h40);
        partner_u.send(8'h3c, 1'b0, 1'b0);
        rd(8'h98, q); `CHK(q, 8'h40)
        wr(8'h98, 8'h50);
        partner_u.send(8'h3c, 1'b0, 1'b0);
        rd(8'h98, q); `CHK(q, 8'h55)
        `CHK(serial_irq, 1'b1)
        rd(8'h99, q); `CHK(q, 8'h3c)
        // mode 3 multiprocessor: address 5a, mask f3
        wr(8'h98, 8'hf0);
        partner_u.send(8'h5b, 1'b1, 1'b1);
        rd(8'h98, q); `CHK(q, 8'hf0)
        partner_u.send(8'h5e, 1'b1, 1'b1);
        rd(8'h98, q); `CHK(q, 8'hf5)
        rd(8'h99, q); `CHK(q, 8'h5e)
        wr(8'h98, 8'h40);
        $display("test rx done");
    endtask
    task automatic t_fifo;
        int k;
        sfr_addr = 8'h99;
        sfr_wr = 1'b1;
        for (k = 0; k < 6; k++) begin sfr_wdata = 8'(k); @(negedge clk); end
        sfr_wr = 1'b0;
        @(negedge clk);
        `CHK(tx_fifo_ready, 1'b0)
        k = 0;
        while (tx_fifo_ready !== 1'b1 && k < 2000) begin @(negedge clk); k++; end
        `CHK(tx_fifo_ready, 1'b1)
        repeat (1000) @(negedge clk);
        $display("test fifo done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_regs();
        t_tx(8'h40, 8'ha5, 9, 11'h1a5);
        t_tx(8'h88, 8'h01, 10, 11'h301);
        double_rate = 1'b0;
        t_tx(8'h80, 8'h81, 10, 11'h281);
        double_rate = 1'b1;
        t_sync(1'b1, 4);
        t_sync(1'b0, 12);
        t_rx();
        t_fifo();
        final_report();
    end
    initial begin
        #300000;
        err_total++;
        final_report();
    end
endmodule // serial_port_sfr_control_tb_top
`default_nettype wire
